// ### acp_pkg.sv
package acp_pkg;

   // Register offsets in the control-port byte space
   localparam logic [7:0] GAIN_CFG_ADDR   = 8'h70;
   localparam logic [7:0] IN_EN_ADDR      = 8'h73;
   localparam logic [7:0] SLOT_EN_ADDR    = 8'h74;
   localparam logic [7:0] POWER_UP_CONFIG_ADDR    = 8'h75;
   localparam logic [7:0] CH_STS_ADDR     = 8'h76;
   localparam logic [7:0] DEVICE_STATE_CODE_ADDR   = 8'h77;

   // Reset values
   localparam logic [3:0] GAIN_LVL_RST    = 4'hE;
   localparam logic [3:0] GAIN_CEIL_RST   = 4'h7;
   localparam logic [7:0] IN_EN_RST       = 8'hF0;
   localparam logic [7:0] SLOT_EN_RST     = 8'h00;
   localparam logic [7:0] POWER_UP_CONFIG_RST     = 8'h00;

   // Field positions in the power configuration register
   localparam int BIAS_BIT    = 7;
   localparam int CHPWR_BIT   = 6;
   localparam int SYNTH_BIT   = 5;
   localparam int DYN_BIT     = 4;
   localparam int SPAN_HI     = 3;
   localparam int SPAN_LO     = 2;

   // Field positions in the gain-controller configuration register
   localparam int LVL_HI      = 7;
   localparam int LVL_LO      = 4;
   localparam int CEIL_HI     = 3;
   localparam int CEIL_LO     = 0;

   // Gain-ceiling codes at and above this are reserved
   localparam logic [3:0] GAIN_CEIL_RSVD  = 4'hE;

   // Mode status codes
   localparam logic [2:0] MODE_SLEEP      = 3'h4;
   localparam logic [2:0] MODE_IDLE       = 3'h6;
   localparam logic [2:0] MODE_RUN        = 3'h7;
   localparam int         MODE_LSB        = 5;

   // Channel count
   localparam int NCH = 8;

   // Gain-controller settings as seen by the processing path
   typedef struct packed {
      logic       active;
      logic [3:0] level;
      logic [3:0] ceiling;
   } acp_gain_t;

   // Power controls as driven to the analog blocks
   typedef struct packed {
      logic bias_gen_power;
      logic synth_power;
   } acp_pwr_t;

   // Host access request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acp_req_t;

endpackage

// ### acp_channel_power_config.sv
// Summary of operation
// - Target level codes map -6 to -36 dB
// - Target level at bits 7-4, resets fourteen
// - Ceiling codes 3 to 42 dB, 14-15 reserved
// - Ceiling at bits 3-0, resets seven
// - Input enable bit7 chan1..bit0 chan8, reset F0
// - Channels 5-8 PDM only, reset disabled
// - Slot enable drives slot, clear tri-states
// - Slot enable register resets to zero
// - Bit 7 powers bias generator
// - Bit 6 powers all enabled channels; in dynamic mode only those inside the span
// - Bit 5 powers the synthesiser
// - Dynamic clear freezes channels while recording
// - Dynamic set allows per-channel power changes
// - Span field selects channels 2,4,6,8
// - Power configuration resets to zero
// - Status bits show channel powered state
// - Mode status reads 4, 6 or 7
// - Gain controller acts only when selected
module acp_channel_power_config (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 ce_i,
   input  wire acp_pkg::acp_req_t    req_i,
   input  wire logic                 gain_loop_select_i,
   input  wire logic                 sleep_i,
   output logic [7:0]                rdata_o,
   output logic                      rvalid_o,
   output acp_pkg::acp_gain_t        gain_o,
   output acp_pkg::acp_pwr_t         pwr_o,
   output logic [7:0]                chan_power_o,
   output logic [7:0]                slot_drive_o,
   output logic [2:0]                device_state_code_o
);

   logic [3:0] gain_target_level_q;
   logic [3:0] gain_ceiling_q;
   logic [7:0] input_channel_enable_q;
   logic [7:0] serial_output_slot_enable_q;
   logic [7:0] power_up_config_q;
   logic [7:0] chan_pwr_d;
   logic [7:0] chan_pwr_q;
   logic [7:0] span_mask;
   logic       recording;
   logic [2:0] mode_d;
   logic       wr_gain;
   logic       wr_in;
   logic       wr_slot;
   logic       wr_pwr;

   // Write decode
   assign wr_gain = ce_i && req_i.wr && (req_i.addr == acp_pkg::GAIN_CFG_ADDR);
   assign wr_in   = ce_i && req_i.wr && (req_i.addr == acp_pkg::IN_EN_ADDR);
   assign wr_slot = ce_i && req_i.wr && (req_i.addr == acp_pkg::SLOT_EN_ADDR);
   assign wr_pwr  = ce_i && req_i.wr && (req_i.addr == acp_pkg::POWER_UP_CONFIG_ADDR);

   // Gain-controller configuration; codes stored as written
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gain_target_level_q <= acp_pkg::GAIN_LVL_RST;
         gain_ceiling_q      <= acp_pkg::GAIN_CEIL_RST;
      end else if (wr_gain) begin
         gain_target_level_q <= req_i.wdata[acp_pkg::LVL_HI:acp_pkg::LVL_LO];
         gain_ceiling_q      <= req_i.wdata[acp_pkg::CEIL_HI:acp_pkg::CEIL_LO];
      end
   end

   // Input channel enables
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         input_channel_enable_q <= acp_pkg::IN_EN_RST;
      end else if (wr_in) begin
         input_channel_enable_q <= req_i.wdata;
      end
   end

   // Serial output slot enables
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         serial_output_slot_enable_q <= acp_pkg::SLOT_EN_RST;
      end else if (wr_slot) begin
         serial_output_slot_enable_q <= req_i.wdata;
      end
   end

   // Power configuration; reserved bits kept as written
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_up_config_q <= acp_pkg::POWER_UP_CONFIG_RST;
      end else if (wr_pwr) begin
         power_up_config_q <= req_i.wdata;
      end
   end

   // Channels reachable in dynamic mode
   always_comb begin
      case (power_up_config_q[acp_pkg::SPAN_HI:acp_pkg::SPAN_LO])
         2'h0:    span_mask = 8'hC0;
         2'h1:    span_mask = 8'hF0;
         2'h2:    span_mask = 8'hFC;
         default: span_mask = 8'hFF;
      endcase
   end

   assign recording = |chan_pwr_q;

   // Next channel power state per channel
   for (genvar i = 0; i < acp_pkg::NCH; i++) begin : g_ch
      always_comb begin
         if (!power_up_config_q[acp_pkg::CHPWR_BIT]) begin
            chan_pwr_d[i] = 1'b0;
         end else if (power_up_config_q[acp_pkg::DYN_BIT]) begin
            chan_pwr_d[i] = input_channel_enable_q[i] & span_mask[i];
         end else if (recording) begin
            chan_pwr_d[i] = chan_pwr_q[i];
         end else begin
            chan_pwr_d[i] = input_channel_enable_q[i];
         end
      end
   end

   // Device mode code
   always_comb begin
      if (sleep_i) begin
         mode_d = acp_pkg::MODE_SLEEP;
      end else if (|chan_pwr_d) begin
         mode_d = acp_pkg::MODE_RUN;
      end else begin
         mode_d = acp_pkg::MODE_IDLE;
      end
   end

   // Channel power state; sleep drops every channel in one edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chan_pwr_q   <= 8'h00;
         chan_power_o <= 8'h00;
      end else if (ce_i) begin
         chan_pwr_q   <= sleep_i ? 8'h00 : chan_pwr_d;
         chan_power_o <= sleep_i ? 8'h00 : chan_pwr_d;
      end
   end

   // Slot drive enables toward the serial port pins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slot_drive_o <= acp_pkg::SLOT_EN_RST;
      end else if (ce_i) begin
         slot_drive_o <= serial_output_slot_enable_q;
      end
   end

   // Mode code; reads sleep until the first enabled edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         device_state_code_o <= acp_pkg::MODE_SLEEP;
      end else if (ce_i) begin
         device_state_code_o <= mode_d;
      end
   end

   // Bias and synthesiser power, one edge behind their bits
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_o <= '0;
      end else if (ce_i) begin
         pwr_o.bias_gen_power <= power_up_config_q[acp_pkg::BIAS_BIT];
         pwr_o.synth_power    <= power_up_config_q[acp_pkg::SYNTH_BIT];
      end
   end

   // Gain-controller settings; reserved ceiling codes pass unchanged
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gain_o <= '0;
      end else if (ce_i) begin
         gain_o.active  <= gain_loop_select_i;
         gain_o.level   <= gain_target_level_q;
         gain_o.ceiling <= gain_ceiling_q;
      end
   end

   // Read data, one cycle after the read request
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o  <= 8'h00;
         rvalid_o <= 1'b0;
      end else if (ce_i) begin
         rvalid_o <= req_i.rd;
         if (req_i.rd) begin
            case (req_i.addr)
               acp_pkg::GAIN_CFG_ADDR: rdata_o <= {gain_target_level_q, gain_ceiling_q};
               acp_pkg::IN_EN_ADDR:    rdata_o <= input_channel_enable_q;
               acp_pkg::SLOT_EN_ADDR:  rdata_o <= serial_output_slot_enable_q;
               acp_pkg::POWER_UP_CONFIG_ADDR:  rdata_o <= power_up_config_q;
               acp_pkg::CH_STS_ADDR:   rdata_o <= chan_pwr_q;
               acp_pkg::DEVICE_STATE_CODE_ADDR: rdata_o <= {device_state_code_o, 5'h00};
               default:                rdata_o <= 8'h00;
            endcase
         end
      end
   end

   // Channel power under the channel power bit
   chpwr_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !power_up_config_q[acp_pkg::CHPWR_BIT]
      |=> chan_pwr_q == 8'h00)
      else $error("channels powered while channel power bit clear");

   nondyn_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !sleep_i && power_up_config_q[acp_pkg::CHPWR_BIT]
      && !power_up_config_q[acp_pkg::DYN_BIT] && !recording
      |=> chan_pwr_q == $past(input_channel_enable_q))
      else $error("enabled channels not powered from idle");

   freeze_rec_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !sleep_i && power_up_config_q[acp_pkg::CHPWR_BIT] && !power_up_config_q[acp_pkg::DYN_BIT]
      && recording && $stable(power_up_config_q)
      |=> $stable(chan_pwr_q))
      else $error("channel changed while recording");

   // Dynamic per-channel power and span
   chan_enabled_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && power_up_config_q[acp_pkg::DYN_BIT]
      |=> (chan_pwr_q & ~$past(input_channel_enable_q)) == 8'h00)
      else $error("disabled channel powered in dynamic mode");

   dyn_grant_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !sleep_i && power_up_config_q[acp_pkg::CHPWR_BIT] && power_up_config_q[acp_pkg::DYN_BIT]
      && power_up_config_q[acp_pkg::SPAN_HI:acp_pkg::SPAN_LO] == 2'h3
      |=> chan_pwr_q == $past(input_channel_enable_q))
      else $error("enabled channel not powered in dynamic mode");

   span_limit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && power_up_config_q[acp_pkg::DYN_BIT] && power_up_config_q[acp_pkg::SPAN_HI:acp_pkg::SPAN_LO] == 2'h0
      |=> (chan_pwr_q & 8'h3F) == 8'h00)
      else $error("channel outside span powered");

   span_wide_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && power_up_config_q[acp_pkg::DYN_BIT] && power_up_config_q[acp_pkg::SPAN_HI:acp_pkg::SPAN_LO] == 2'h1
      |=> (chan_pwr_q & 8'h0F) == 8'h00)
      else $error("channel outside four-channel span powered");

   span_mid_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && power_up_config_q[acp_pkg::DYN_BIT] && power_up_config_q[acp_pkg::SPAN_HI:acp_pkg::SPAN_LO] == 2'h2
      |=> (chan_pwr_q & 8'h03) == 8'h00)
      else $error("channel outside six-channel span powered");

   // Mode status
   mode_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && !sleep_i
      |=> device_state_code_o == ((chan_pwr_q != 8'h00) ? acp_pkg::MODE_RUN : acp_pkg::MODE_IDLE))
      else $error("mode status mismatch");

   sleep_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && sleep_i
      |=> device_state_code_o == acp_pkg::MODE_SLEEP && chan_pwr_q == 8'h00)
      else $error("sleep not reflected in mode or channels");

   mode_rd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && req_i.addr == acp_pkg::DEVICE_STATE_CODE_ADDR
      |=> rdata_o[7:acp_pkg::MODE_LSB] == $past(device_state_code_o))
      else $error("mode status readback wrong");

   // Slot enables
   slot_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_slot
      |=> serial_output_slot_enable_q == $past(req_i.wdata))
      else $error("slot enable write not stored");

   slot_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_slot ##1 ce_i
      |=> slot_drive_o == $past(req_i.wdata, 2))
      else $error("slot drive not following write");

   slot_rd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && req_i.addr == acp_pkg::SLOT_EN_ADDR
      |=> rdata_o == $past(serial_output_slot_enable_q))
      else $error("slot enable readback wrong");

   // Input enables, power configuration and status
   in_en_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_in
      |=> input_channel_enable_q == $past(req_i.wdata))
      else $error("input enable write not stored");

   in_en_rd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && req_i.addr == acp_pkg::IN_EN_ADDR
      |=> rdata_o == $past(input_channel_enable_q))
      else $error("input enable readback wrong");

   pwr_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_pwr
      |=> power_up_config_q == $past(req_i.wdata))
      else $error("power configuration write not stored");

   bias_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_pwr ##1 ce_i
      |=> pwr_o.bias_gen_power == $past(req_i.wdata[acp_pkg::BIAS_BIT], 2))
      else $error("bias power not following write");

   synth_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_pwr ##1 ce_i
      |=> pwr_o.synth_power == $past(req_i.wdata[acp_pkg::SYNTH_BIT], 2))
      else $error("synthesiser power not following write");

   status_rd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && req_i.addr == acp_pkg::CH_STS_ADDR
      |=> rdata_o == $past(chan_pwr_q))
      else $error("channel status readback wrong");

   // Gain-controller settings
   gain_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_gain
      |=> {gain_target_level_q, gain_ceiling_q} == $past(req_i.wdata))
      else $error("gain config write not stored");

   gain_rd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i && req_i.rd && req_i.addr == acp_pkg::GAIN_CFG_ADDR
      |=> rdata_o == {$past(gain_target_level_q), $past(gain_ceiling_q)})
      else $error("gain config readback wrong");

   gain_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i
      |=> gain_o.level == $past(gain_target_level_q))
      else $error("target level not passed on");

   gain_ceil_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i
      |=> gain_o.ceiling == $past(gain_ceiling_q))
      else $error("gain ceiling not passed on");

   gain_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ce_i
      |=> gain_o.active == $past(gain_loop_select_i))
      else $error("gain controller select not passed on");

   // Main scenarios
   run_c:   cover property (@(posedge clk_i) device_state_code_o == acp_pkg::MODE_RUN);
   dyn_c:   cover property (@(posedge clk_i) power_up_config_q[acp_pkg::DYN_BIT] && recording);
   slot_c:  cover property (@(posedge clk_i) slot_drive_o == 8'hFF);
   sleep_c: cover property (@(posedge clk_i) sleep_i && device_state_code_o == acp_pkg::MODE_SLEEP);
   rsvd_c:  cover property (@(posedge clk_i) gain_o.ceiling >= acp_pkg::GAIN_CEIL_RSVD);

endmodule

// ### acp_host_model.sv
// Host side of the control port, same-clock request levels
module acp_host_model (
   input  wire logic         clk_i,
   output acp_pkg::acp_req_t req_o,
   input  wire logic [7:0]   rdata_i,
   input  wire logic         rvalid_i
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle request at time zero
   initial req_o = '0;

   // One write, held across its taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      req_o.wr    = 1'b1;
      req_o.addr  = a;
      req_o.wdata = (a == acp_pkg::POWER_UP_CONFIG_ADDR) ? {d[7:2], 2'b00} : d;
      @(posedge clk_i);
      #1;
      req_o.wr    = 1'b0;
      req_o.wdata = ~req_o.wdata; // Stale data must not look valid
   endtask

   // One read; answer registered at the taking edge, valid one cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk_i);
      #1;
      req_o.rd   = 1'b1;
      req_o.addr = a;
      @(posedge clk_i);
      #1;
      d = rdata_i;
      v = rvalid_i;
      req_o.rd   = 1'b0;
   endtask
endmodule

// ### tb.sv
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end

module tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic                clk_i, rst_n_i, ce, sel_i, sleep_i, rvalid;
   acp_pkg::acp_req_t   req;
   logic [7:0]          rdata, chan, slot;
   acp_pkg::acp_gain_t  gain;
   acp_pkg::acp_pwr_t   pwr;
   logic [2:0]          mode;
   int                  miscompares = 0;
   int                  n_tests = 0;
   logic [7:0]          span_exp [4] = '{8'hC0, 8'hF0, 8'hFC, 8'hFF};

   acp_channel_power_config dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .req_i(req),
      .gain_loop_select_i(sel_i), .sleep_i(sleep_i), .rdata_o(rdata), .rvalid_o(rvalid), .gain_o(gain),
      .pwr_o(pwr), .chan_power_o(chan), .slot_drive_o(slot), .device_state_code_o(mode));
   acp_host_model host_u (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

   // Free-running 10 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   // Read one register and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      host_u.rd(a, d, v);
      `CHK("rvalid", 1'b1, v)
      `CHK("rdata", e, d)
   endtask

   // Let the registered outputs follow a write
   task automatic settle();
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic t_reset();
      rchk(acp_pkg::GAIN_CFG_ADDR, 8'hE7);
      rchk(acp_pkg::IN_EN_ADDR, 8'hF0);
      rchk(acp_pkg::SLOT_EN_ADDR, 8'h00);
      rchk(acp_pkg::POWER_UP_CONFIG_ADDR, 8'h00);
      rchk(acp_pkg::CH_STS_ADDR, 8'h00);
      rchk(acp_pkg::DEVICE_STATE_CODE_ADDR, 8'hC0);
      `CHK("slot", 8'h00, slot)
      `CHK("pwr", 2'b00, pwr)
      `CHK("gain", 9'h0E7, gain)
   endtask

   task automatic t_gain();
      host_u.wr(acp_pkg::GAIN_CFG_ADDR, 8'h0E);
      sel_i = 1'b1;
      settle();
      `CHK("gain", 9'h10E, gain)
      rchk(acp_pkg::GAIN_CFG_ADDR, 8'h0E);
   endtask

   task automatic t_slots();
      host_u.wr(acp_pkg::SLOT_EN_ADDR, 8'hA5);
      host_u.wr(acp_pkg::CH_STS_ADDR, 8'hFF);
      settle();
      `CHK("slot", 8'hA5, slot)
      rchk(acp_pkg::CH_STS_ADDR, 8'h00);
      rchk(8'h80, 8'h00);
      host_u.wr(acp_pkg::SLOT_EN_ADDR, 8'hFF);
      settle();
      `CHK("slot", 8'hFF, slot)
      ce = 1'b0;
      host_u.wr(acp_pkg::SLOT_EN_ADDR, 8'h00);
      settle();
      `CHK("slot", 8'hFF, slot)
      ce = 1'b1;
      rchk(acp_pkg::SLOT_EN_ADDR, 8'hFF);
   endtask

   task automatic t_power();
      host_u.wr(acp_pkg::POWER_UP_CONFIG_ADDR, 8'hE3);
      settle();
      `CHK("pwr", 2'b11, pwr)
      `CHK("chan", 8'hF0, chan)
      `CHK("mode", acp_pkg::MODE_RUN, mode)
      rchk(acp_pkg::CH_STS_ADDR, 8'hF0);
      rchk(acp_pkg::POWER_UP_CONFIG_ADDR, 8'hE0);
      host_u.wr(acp_pkg::IN_EN_ADDR, 8'h0F);
      settle();
      `CHK("chan", 8'hF0, chan)
      host_u.wr(acp_pkg::POWER_UP_CONFIG_ADDR, 8'h00);
      settle();
      `CHK("chan", 8'h00, chan)
      `CHK("mode", acp_pkg::MODE_IDLE, mode)
   endtask

   task automatic t_dynamic();
      host_u.wr(acp_pkg::IN_EN_ADDR, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         host_u.wr(acp_pkg::POWER_UP_CONFIG_ADDR, 8'h50 | 8'(i << 2));
         settle();
         `CHK("span", span_exp[i], chan)
      end
      host_u.wr(acp_pkg::IN_EN_ADDR, 8'h30);
      settle();
      `CHK("chan", 8'h30, chan)
      sleep_i = 1'b1;
      settle();
      `CHK("chan", 8'h00, chan)
      `CHK("mode", acp_pkg::MODE_SLEEP, mode)
      sleep_i = 1'b0;
   endtask

   // Verdict and end of run
   task automatic close_out();
      if (miscompares == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #100us;
      miscompares++;
      close_out();
   end

   // Main sequence
   initial begin
      rst_n_i = 1'b0;
      ce      = 1'b1;
      sel_i   = 1'b0;
      sleep_i = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      `CHK("mode", acp_pkg::MODE_SLEEP, mode)
      t_reset();
      t_gain();
      t_slots();
      t_power();
      t_dynamic();
      close_out();
   end
endmodule
